// File: logic/dio_map.svh
// register indices, field positions and reset values of the i/o ports
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH
`define DIO_IDX_B_DATA  8'h06
`define DIO_IDX_B_DIR   8'h86
`define DIO_IDX_OPTION  8'h81
`define DIO_IDX_C_DATA  8'h07
`define DIO_IDX_C_DIR   8'h87
`define DIO_PU_BIT      7
`define DIO_B_IRQ_BIT   0
`define DIO_B_SS_BIT    1
`define DIO_B_AN_BIT    2
`define DIO_DIR_RST     8'hFF
`define DIO_LAT_POR     8'h00
`define DIO_PU_N_RST    1'b1
`define DIO_ZERO8       8'h00
`define DIO_ONES8       8'hFF
`endif

// File: logic/dio_pkg.sv
// types shared by the dual i/o port logic
package dio_pkg;
  typedef enum logic [2:0] {
    DIO_SEL_NONE,
    DIO_SEL_B_DATA,
    DIO_SEL_B_DIR,
    DIO_SEL_OPTION,
    DIO_SEL_C_DATA,
    DIO_SEL_C_DIR
  } dio_sel_t;

  typedef struct packed {
    logic [7:0] b_lat;
    logic [7:0] b_dir;
    logic [7:0] c_lat;
    logic [7:0] c_dir;
    logic       pu_n;
    logic [7:0] b_s1;
    logic [7:0] b_s2;
    logic [7:0] c_s1;
    logic [7:0] c_s2;
    logic [7:0] b_o;
    logic [7:0] b_oe;
    logic [7:0] b_pu;
    logic [7:0] c_o;
    logic [7:0] c_oe;
    logic [7:0] c_in;
    logic       irq_lvl;
    logic       ss_lvl;
    logic       pready;
    logic       pslverr;
    logic [7:0] prdata;
  } dio_state_t;
endpackage : dio_pkg

// File: logic/dio_ports.sv
// two 8-bit general purpose i/o ports behind an apb slave
//
// Functional notes
// R1: second port eight bits with direction register
// R2: direction bit one makes pin input
// R3: direction bit zero drives latch onto pin
// R4: option bit seven low enables all pull-ups
// R5: output pins never get a pull-up
// R6: pull-ups off after reset
// R7: second port bit 0 feeds external interrupt
// R8: second port bit 1 feeds slave select
// R9: second port bit 2 is analog channel 8
// R10: third port bit 0 timer osc/clock
// R11: third port bit 1 timer osc or ccu2
// R12: third port bit 2 gpio or ccu1
// R13: third port bit 3 serial clock
// R14: third port bit 4 serial data in/sda
// R15: third port bit 5 serial data out
// R16: third port bit 6 usart tx/clock
// R17: third port bit 7 usart rx/data
// R18: third port direction resets to all ones
// R19: third port latch kept on non-power-on reset
// R20: writes hit latch, reads return pin levels
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "dio_map.svh"

module dio_ports
  import dio_pkg::*;
#(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          por_reset,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // second port pins
  input  wire logic [7:0]    pins_b_i,
  output logic      [7:0]    pins_b_o,
  output logic      [7:0]    pins_b_oe,
  output logic      [7:0]    pins_b_pu,
  // second port shared functions
  input  wire logic          analog_ch8_en,
  output logic               ext_irq_level,
  output logic               slave_select_level,
  // third port pins
  input  wire logic [7:0]    pins_c_i,
  output logic      [7:0]    pins_c_o,
  output logic      [7:0]    pins_c_oe,
  // third port peripheral overrides
  input  wire logic [7:0]    alt_c_en,
  input  wire logic [7:0]    alt_c_o,
  input  wire logic [7:0]    alt_c_oe,
  output logic      [7:0]    alt_c_in
);

  dio_state_t st_reg;
  dio_state_t st_next;
  dio_sel_t   sel;
  logic       setup;
  logic       access;
  logic [7:0] b_view;
  logic [7:0] keep_b;
  logic [7:0] keep_c;

  function automatic logic idx_hit(input logic [AW-1:0] a,
                                   input logic [7:0]    idx);
    logic [AW-1:0] byte_addr;
    byte_addr = AW'({idx, 2'b00});
    return a == byte_addr;
  endfunction : idx_hit

  function automatic dio_sel_t dio_decode(input logic [AW-1:0] a);
    dio_sel_t s;
    s = DIO_SEL_NONE;
    if (idx_hit(a, `DIO_IDX_B_DATA)) begin
      s = DIO_SEL_B_DATA;
    end
    if (idx_hit(a, `DIO_IDX_B_DIR)) begin
      s = DIO_SEL_B_DIR;
    end
    if (idx_hit(a, `DIO_IDX_OPTION)) begin
      s = DIO_SEL_OPTION;
    end
    if (idx_hit(a, `DIO_IDX_C_DATA)) begin
      s = DIO_SEL_C_DATA;
    end
    if (idx_hit(a, `DIO_IDX_C_DIR)) begin
      s = DIO_SEL_C_DIR;
    end
    return s;
  endfunction : dio_decode

  always_comb begin
    st_next = st_reg;
    sel     = dio_decode(paddr);
    setup   = psel && !penable;
    access  = psel && penable && st_reg.pready;
    keep_b  = st_reg.b_lat;
    keep_c  = st_reg.c_lat;

    // two-stage pin synchronisers
    st_next.b_s1 = pins_b_i;
    st_next.b_s2 = st_reg.b_s1;
    st_next.c_s1 = pins_c_i;
    st_next.c_s2 = st_reg.c_s1;

    // analog channel blanks the digital read of its pin
    b_view = st_reg.b_s2;
    if (analog_ch8_en) begin
      b_view[`DIO_B_AN_BIT] = 1'b0; // R9
    end

    // register writes at the access edge
    if (access && pwrite && pstrb[0]) begin
      unique case (sel)
        DIO_SEL_B_DATA: st_next.b_lat = pwdata[7:0]; // R20
        DIO_SEL_B_DIR:  st_next.b_dir = pwdata[7:0]; // R1
        DIO_SEL_OPTION: st_next.pu_n  = pwdata[`DIO_PU_BIT]; // R4
        DIO_SEL_C_DATA: st_next.c_lat = pwdata[7:0]; // R20
        DIO_SEL_C_DIR:  st_next.c_dir = pwdata[7:0];
        DIO_SEL_NONE:   st_next.pslverr = 1'b1;
      endcase
    end

    // answer prepared in setup, shown in the first access cycle
    st_next.pready  = setup;
    st_next.pslverr = setup && (sel == DIO_SEL_NONE);
    st_next.prdata  = `DIO_ZERO8;
    if (setup && !pwrite) begin
      unique case (sel)
        DIO_SEL_B_DATA: st_next.prdata = b_view; // R20
        DIO_SEL_B_DIR:  st_next.prdata = st_reg.b_dir;
        DIO_SEL_OPTION: begin
          st_next.prdata[`DIO_PU_BIT] = st_reg.pu_n;
        end
        DIO_SEL_C_DATA: st_next.prdata = st_reg.c_s2; // R20
        DIO_SEL_C_DIR:  st_next.prdata = st_reg.c_dir;
        DIO_SEL_NONE:   st_next.prdata = `DIO_ZERO8;
      endcase
    end

    // second port drivers: one is input, zero drives the latch
    st_next.b_o  = st_next.b_lat; // R3
    st_next.b_oe = ~st_next.b_dir; // R2
    if (analog_ch8_en) begin
      st_next.b_oe[`DIO_B_AN_BIT] = 1'b0; // R9
    end
    // shared enable, masked to input pins only
    st_next.b_pu = st_next.pu_n ? `DIO_ZERO8 : st_next.b_dir; // R4 R5

    // shared input functions of the second port
    st_next.irq_lvl = st_reg.b_s2[`DIO_B_IRQ_BIT]; // R7
    st_next.ss_lvl  = st_reg.b_s2[`DIO_B_SS_BIT]; // R8

    // third port: a peripheral takes a pin while its enable is high
    // bit0 timer osc out/clk in, bit1 timer osc in/ccu2,
    // bit2 ccu1, bit3 serial clock, bit4 serial data in/sda,
    // bit5 serial data out, bit6 usart tx/clk, bit7 usart rx/data
    for (int i = 0; i < 8; i++) begin
      if (alt_c_en[i]) begin
        st_next.c_o[i]  = alt_c_o[i]; // R10 R11 R12 R13
        st_next.c_oe[i] = alt_c_oe[i]; // R14 R15 R16 R17
      end else begin
        st_next.c_o[i]  = st_next.c_lat[i]; // R3
        st_next.c_oe[i] = ~st_next.c_dir[i]; // R2
      end
    end
    st_next.c_in = st_reg.c_s2; // R10 R13 R14 R17

    if (srst) begin
      if (por_reset) begin
        keep_b = `DIO_LAT_POR;
        keep_c = `DIO_LAT_POR;
      end
      st_next       = '0;
      st_next.b_dir = `DIO_DIR_RST;
      st_next.c_dir = `DIO_DIR_RST; // R18
      st_next.pu_n  = `DIO_PU_N_RST; // R6
      st_next.b_lat = keep_b;
      st_next.c_lat = keep_c; // R19
    end
  end

  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  assign prdata             = {24'h000000, st_reg.prdata};
  assign pready             = st_reg.pready;
  assign pslverr            = st_reg.pslverr;
  assign pins_b_o           = st_reg.b_o;
  assign pins_b_oe          = st_reg.b_oe;
  assign pins_b_pu          = st_reg.b_pu;
  assign ext_irq_level      = st_reg.irq_lvl;
  assign slave_select_level = st_reg.ss_lvl;
  assign pins_c_o           = st_reg.c_o;
  assign pins_c_oe          = st_reg.c_oe;
  assign alt_c_in           = st_reg.c_in;

  // checks
  logic wr_b_dir;
  logic wr_b_dat;
  logic wr_c_dir;
  logic rd_c_set;
  assign wr_b_dir = access && pwrite && pstrb[0] &&
                    idx_hit(paddr, `DIO_IDX_B_DIR);
  assign wr_b_dat = access && pwrite && pstrb[0] &&
                    idx_hit(paddr, `DIO_IDX_B_DATA);
  assign wr_c_dir = access && pwrite && pstrb[0] &&
                    idx_hit(paddr, `DIO_IDX_C_DIR) && alt_c_en == 8'h00;
  assign rd_c_set = setup && !pwrite && idx_hit(paddr, `DIO_IDX_C_DATA);

  a_b_dir_hiz: assert property ( // R2
    @(posedge clk_sys) disable iff (srst)
    wr_b_dir && !analog_ch8_en |=>
      pins_b_oe == ~$past(pwdata[7:0]))
    else $error("second port enable does not follow direction");

  a_b_drive_latch: assert property ( // R3
    @(posedge clk_sys) disable iff (srst)
    wr_b_dat |=> pins_b_o == $past(pwdata[7:0]))
    else $error("second port latch not driven");

  a_c_dir_hiz: assert property ( // R2
    @(posedge clk_sys) disable iff (srst)
    wr_c_dir |=>
      pins_c_oe == ~$past(pwdata[7:0]))
    else $error("third port enable does not follow direction");

  a_pu_shared: assert property ( // R4
    @(posedge clk_sys) disable iff (srst)
    pins_b_pu != 8'h00 |-> (pins_b_pu | pins_b_oe) == `DIO_ONES8 ||
      analog_ch8_en)
    else $error("pull-ups not applied to all inputs");

  a_pu_outputs: assert property ( // R5
    @(posedge clk_sys) disable iff (srst)
    (pins_b_pu & pins_b_oe) == 8'h00)
    else $error("pull-up active on an output pin");

  a_pu_after_rst: assert property ( // R6
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> (pins_b_pu == 8'h00) [*2])
    else $error("pull-ups enabled after reset");

  a_irq_follow: assert property ( // R7
    @(posedge clk_sys) disable iff (srst)
    (pins_b_i[0] && !srst) [*4] |-> ext_irq_level)
    else $error("interrupt level does not follow pin");

  a_ss_follow: assert property ( // R8
    @(posedge clk_sys) disable iff (srst)
    (!pins_b_i[1] && !srst) [*4] |-> !slave_select_level)
    else $error("slave select does not follow pin");

  a_c_dir_reset: assert property ( // R18
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> st_reg.c_dir == `DIO_DIR_RST)
    else $error("third port direction not all inputs");

  a_c_lat_keep: assert property ( // R19
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) && !$past(por_reset) && $past(srst, 2) |->
      st_reg.c_lat == $past(st_reg.c_lat))
    else $error("third port latch lost on reset");

  a_c_read_pins: assert property ( // R20
    @(posedge clk_sys) disable iff (srst)
    rd_c_set |=> pready && prdata[7:0] == $past(st_reg.c_s2))
    else $error("third port read is not the pin level");

  a_unmapped_err: assert property (
    @(posedge clk_sys) disable iff (srst)
    setup && dio_decode(paddr) == DIO_SEL_NONE |=>
      pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped address not refused");

  // bus timing
  a_pready_pulse: assert property (
    @(posedge clk_sys) disable iff (srst)
    !srst |=> pready == $past(setup))
    else $error("ready not one cycle after setup");

  // reset values
  a_b_dir_reset: assert property ( // R6
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> st_reg.b_dir == `DIO_DIR_RST && st_reg.pu_n)
    else $error("second port not inputs without pull-ups after reset");

  a_c_lat_por: assert property ( // R19
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) && $past(por_reset) |-> st_reg.c_lat == `DIO_LAT_POR)
    else $error("third port latch not cleared on power-on");

  // analog channel
  a_an_driver_off: assert property ( // R9
    @(posedge clk_sys) disable iff (srst)
    analog_ch8_en |=> !pins_b_oe[`DIO_B_AN_BIT])
    else $error("analog pin still driven");

  a_an_read_zero: assert property ( // R9
    @(posedge clk_sys) disable iff (srst)
    setup && !pwrite && analog_ch8_en && sel == DIO_SEL_B_DATA |=>
      !prdata[`DIO_B_AN_BIT])
    else $error("analog pin read as a digital level");

  // third port peripheral takeover
  a_c_alt_out: assert property ( // R16
    @(posedge clk_sys) disable iff (srst)
    !srst |=> ((pins_c_o ^ $past(alt_c_o)) & $past(alt_c_en)) == 8'h00)
    else $error("peripheral does not drive its pin value");

  a_c_alt_oe: assert property ( // R14
    @(posedge clk_sys) disable iff (srst)
    !srst |=> ((pins_c_oe ^ $past(alt_c_oe)) & $past(alt_c_en)) == 8'h00)
    else $error("peripheral does not own its pin enable");

  a_c_alt_in: assert property ( // R17
    @(posedge clk_sys) disable iff (srst)
    (!srst) [*4] |-> alt_c_in == $past(pins_c_i, 3))
    else $error("peripheral input does not follow its pin");

  c_pullups_on: cover property (
    @(posedge clk_sys) disable iff (srst) pins_b_pu != 8'h00);
  c_alt_drive: cover property (
    @(posedge clk_sys) disable iff (srst) alt_c_en != 8'h00 ##1
    pins_c_oe != 8'h00);
  c_write_dir: cover property (
    @(posedge clk_sys) disable iff (srst) wr_b_dir);
  c_read_c: cover property (
    @(posedge clk_sys) disable iff (srst) rd_c_set);
  c_an_read: cover property (
    @(posedge clk_sys) disable iff (srst)
    setup && !pwrite && analog_ch8_en && sel == DIO_SEL_B_DATA);

endmodule : dio_ports

// File: tb/dio_board.sv
// board-side pin model: design drive, external drive, pull-ups, floating
`timescale 1ns/1ps
module dio_board (
  // clock
  input  wire logic       clk_sys,
  // design drive
  input  wire logic [7:0] b_o,
  input  wire logic [7:0] b_oe,
  input  wire logic [7:0] b_pu,
  input  wire logic [7:0] c_o,
  input  wire logic [7:0] c_oe,
  // external drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_c,
  // resolved levels
  output logic      [7:0] b_lvl,
  output logic      [7:0] c_lvl
);
  logic [7:0] flt = 8'h55;
  // undriven lines wander every cycle
  always @(posedge clk_sys) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      b_lvl[i] = b_oe[i] ? b_o[i] : ext_en[i] ? ext_b[i] :
                 b_pu[i] ? 1'b1 : flt[i];
      c_lvl[i] = c_oe[i] ? c_o[i] : ext_en[i] ? ext_c[i] : flt[i];
    end
  end
endmodule : dio_board

// File: tb/tb_dio_ports.sv
// self-checking bench for the dual i/o port block
`timescale 1ns/1ps
`include "dio_map.svh"
module tb_dio_ports;
  logic        clk_sys = 1'b0, srst = 1'b1, por_reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0]  b_i, b_o, b_oe, b_pu, c_i, c_o, c_oe, alt_in;
  logic        an_en = 1'b0, irq, ss;
  logic [7:0]  alt_en = 8'h00, alt_o = 8'h00, alt_oe = 8'h00;
  logic [7:0]  ext_en = 8'h00, ext_b = 8'h00, ext_c = 8'h00, v, r;
  logic [8:0]  exp_q[$];
  int          n_fail = 0, tests_run = 0;

  always #50 clk_sys = ~clk_sys;

  dio_ports #(.AW(12)) u_dio_ports (.clk_sys(clk_sys), .srst(srst),
    .por_reset(por_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_b_i(b_i), .pins_b_o(b_o), .pins_b_oe(b_oe), .pins_b_pu(b_pu),
    .analog_ch8_en(an_en), .ext_irq_level(irq), .slave_select_level(ss),
    .pins_c_i(c_i), .pins_c_o(c_o), .pins_c_oe(c_oe), .alt_c_en(alt_en),
    .alt_c_o(alt_o), .alt_c_oe(alt_oe), .alt_c_in(alt_in));

  dio_board u_dio_board (.clk_sys(clk_sys), .b_o(b_o), .b_oe(b_oe),
    .b_pu(b_pu), .c_o(c_o), .c_oe(c_oe), .ext_en(ext_en), .ext_b(ext_b),
    .ext_c(ext_c), .b_lvl(b_i), .c_lvl(c_i));

  task check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    tests_run++;
    if (seen !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // one apb transfer; reads note {err, data} for the monitor
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
           input logic [8:0] e);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!wr) exp_q.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!pready && k < 20);
    if (!pready) begin
      n_fail++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 9'h000);
  endtask : wr

  task rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, {1'b0, e});
  endtask : rd

  task idle;
    repeat (6) @(posedge clk_sys);
  endtask : idle

  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check("rd_data", prdata[7:0], exp_q[0][7:0]);
      check("rd_err", {7'h0, pslverr}, {7'h0, exp_q[0][8]});
      void'(exp_q.pop_front());
    end
  end

  initial begin
    r = 8'($urandom(45801));
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`DIO_IDX_C_DIR, 8'hFF);
    rd(`DIO_IDX_OPTION, 8'h80);
    check("b_pu", b_pu, 8'h00);
    check("c_oe", c_oe, 8'h00);
    v = 8'($urandom);
    wr(`DIO_IDX_C_DATA, v);
    wr(`DIO_IDX_C_DIR, 8'h00);
    idle();
    check("c_o", c_o, v);
    check("c_oe", c_oe, 8'hFF);
    rd(`DIO_IDX_C_DATA, v);
    r = 8'($urandom);
    ext_c <= r;
    ext_en <= 8'hFF;
    wr(`DIO_IDX_C_DIR, 8'hFF);
    idle();
    check("c_oe", c_oe, 8'h00);
    rd(`DIO_IDX_C_DATA, r);
    // pull-ups on inputs only, and only with the control bit low
    ext_en <= 8'h00;
    wr(`DIO_IDX_OPTION, 8'h00);
    wr(`DIO_IDX_B_DIR, 8'h0F);
    wr(`DIO_IDX_B_DATA, 8'hA5);
    idle();
    check("b_pu", b_pu, 8'h0F);
    check("b_oe", b_oe, 8'hF0);
    check("b_o", b_o, 8'hA5);
    rd(`DIO_IDX_B_DATA, 8'hAF);
    wr(`DIO_IDX_OPTION, 8'h80);
    idle();
    check("b_pu", b_pu, 8'h00);
    an_en <= 1'b1;
    wr(`DIO_IDX_B_DIR, 8'h00);
    idle();
    check("b_oe", b_oe, 8'hFB);
    rd(`DIO_IDX_B_DATA, 8'hA1);
    an_en <= 1'b0;
    for (int j = 1; j < 3; j++) begin
      wr(`DIO_IDX_B_DATA, j[7:0]);
      idle();
      check("irq", {7'h0, irq}, {7'h0, j[0]});
      check("ss", {7'h0, ss}, {7'h0, j[1]});
    end
    r = 8'($urandom);
    alt_en <= 8'hFF;
    alt_o <= r;
    alt_oe <= 8'hF0;
    ext_c <= ~r;
    ext_en <= 8'hFF;
    idle();
    check("alt_o", c_o & 8'hF0, r & 8'hF0);
    check("alt_oe", c_oe, 8'hF0);
    check("alt_in", alt_in, {r[7:4], ~r[3:0]});
    alt_en <= 8'h00;
    ext_en <= 8'h00;
    apb(1'b0, 8'h10, 8'h00, 9'h100);
    srst <= 1'b1;
    por_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`DIO_IDX_C_DIR, 8'hFF);
    wr(`DIO_IDX_C_DIR, 8'h00);
    idle();
    check("c_keep", c_o, v);
    srst <= 1'b1;
    por_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    wr(`DIO_IDX_C_DIR, 8'h00);
    idle();
    check("c_por", c_o, 8'h00);
    check("exp_q", 8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule : tb_dio_ports
